// ===== pkg/spc_pkg.sv
// Constants, register map and state encoding of the sleep and power control
package spc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] SPC_IDX_CORE   = 8'h35;
  localparam logic [7:0] SPC_IDX_SLEEP  = 8'h33;
  localparam logic [7:0] SPC_IDX_GATE   = 8'h34;
  localparam logic [7:0] SPC_IDX_STATUS = 8'h36;

  // Sleep control register fields
  localparam int SPC_SE_BIT      = 0;
  localparam int SPC_SM_LSB      = 1;
  localparam int SPC_SLEEP_WIDTH = 3;

  // Core control register fields
  localparam int SPC_PUD_BIT    = 4;
  localparam int SPC_UNLOCK_BIT = 5;
  localparam int SPC_BROWNOUT_SLEEP_OFF_BIT   = 6;

  // Clock gate register bits
  localparam int SPC_GATE_ADC   = 0;
  localparam int SPC_GATE_USI   = 1;
  localparam int SPC_GATE_TIM0  = 2;
  localparam int SPC_GATE_TIM1  = 3;
  localparam int SPC_GATE_SPI   = 4;
  localparam int SPC_GATE_LIN   = 5;
  localparam int SPC_GATE_WIDTH = 6;

  // Reset values
  localparam logic [2:0] SPC_SLEEP_RST = 3'h0;
  localparam logic [5:0] SPC_GATE_RST  = 6'h00;

  // Sleep mode choice encodings
  localparam logic [1:0] SPC_MODE_IDLE = 2'h0;
  localparam logic [1:0] SPC_MODE_ADCN = 2'h1;
  localparam logic [1:0] SPC_MODE_PDWN = 2'h2;
  localparam logic [1:0] SPC_MODE_PSAV = 2'h3;

  // Cycle counts
  localparam logic [2:0] SPC_UNLOCK_CYC   = 3'h4;
  localparam logic [2:0] SPC_BROWNOUT_SLEEP_OFF_CYC     = 3'h6;
  localparam logic [2:0] SPC_BROWNOUT_SLEEP_OFF_ACT_MAX = 3'h3;
  localparam logic [2:0] SPC_WAKE_HALT    = 3'h4;
  localparam logic [15:0] SPC_STARTUP_DEF = 16'h0010;

  typedef enum logic [3:0] {
    SPC_ST_RUN   = 4'b0001,
    SPC_ST_SLEEP = 4'b0010,
    SPC_ST_START = 4'b0100,
    SPC_ST_HALT  = 4'b1000
  } spc_fsm_type;

endpackage

// ===== hw/spc_sleep_power_ctrl.sv
// Sleep mode, clock gating and brown-out sleep-off control with APB registers
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps

module spc_sleep_power_ctrl #(
  parameter logic [15:0] STARTUP_CYC = spc_pkg::SPC_STARTUP_DEF
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // CPU core
  input  wire logic        sleep_instr_i,
  input  wire logic        wake_i,
  output logic             cpu_halt_o,
  // Clock domain enables
  output logic             clk_cpu_en_o,
  output logic             clk_io_en_o,
  output logic             clk_adc_en_o,
  output logic             clk_asy_en_o,
  output logic             main_osc_en_o,
  output logic      [5:0]  periph_clk_en_o,
  // Fuses and module requests
  input  wire logic [2:0]  brownout_level_fuses_i,
  input  wire logic        onchip_debug_fuse_i,
  input  wire logic        adc_enable_i,
  input  wire logic        adc_conv_start_i,
  input  wire logic        acomp_enable_i,
  input  wire logic        acomp_uses_ref_i,
  input  wire logic        wdt_enable_i,
  input  wire logic [15:0] wake_pin_need_i,
  // Analog and pin controls
  output logic             adc_en_o,
  output logic             adc_extended_conv_o,
  output logic             acomp_en_o,
  output logic             vref_en_o,
  output logic             wdt_run_o,
  output logic             brownout_en_o,
  output logic      [15:0] input_buf_en_o,
  output logic             pullup_disable_o
);

  typedef struct packed {
    spc_pkg::spc_fsm_type state;
    logic [1:0]  mode;
    logic [15:0] su_cnt;
    logic [2:0]  halt_cnt;
    logic [2:0]  sleep_ctl;
    logic [5:0]  gate;
    logic        pullup_disable;
    logic [2:0]  brownout_sleep_off_cnt;
    logic [2:0]  unlock_cnt;
    logic        bod_off;
    logic        adc_prev;
    logic        ext_conv;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cpu_halt;
    logic        clk_cpu;
    logic        clk_io;
    logic        clk_adc;
    logic        clk_asy;
    logic        main_osc;
    logic [5:0]  periph_clk;
    logic        adc_en;
    logic        acomp_en;
    logic        vref_en;
    logic        wdt_run;
    logic        bod_en;
    logic [15:0] inbuf;
  } spc_state_type;

  spc_state_type state_reg;
  spc_state_type state_next;

  function automatic logic addr_hit(input logic [11:0] a,
                                    input logic [7:0]  idx);
    addr_hit = (a == {2'h0, idx, 2'h0});
  endfunction

  function automatic logic deep_mode(input logic [1:0] m);
    deep_mode = (m == spc_pkg::SPC_MODE_PDWN) ||
                (m == spc_pkg::SPC_MODE_PSAV);
  endfunction

  logic setup_ph;
  logic wr_en;
  logic hit_core;
  logic hit_sleep;
  logic hit_gate;
  logic hit_stat;
  logic brownout_sleep_off_bit;
  logic brownout_sleep_off_active;
  logic fuse_bod;
  logic sleeping;
  logic deep;

  assign setup_ph  = psel_i && !penable_i;
  // A write lands only at the access edge where the answer is given
  assign wr_en     = psel_i && penable_i && pwrite_i && state_reg.pready;
  assign hit_core  = addr_hit(paddr_i, spc_pkg::SPC_IDX_CORE);
  assign hit_sleep = addr_hit(paddr_i, spc_pkg::SPC_IDX_SLEEP);
  assign hit_gate  = addr_hit(paddr_i, spc_pkg::SPC_IDX_GATE);
  assign hit_stat  = addr_hit(paddr_i, spc_pkg::SPC_IDX_STATUS);
  assign brownout_sleep_off_bit  = (state_reg.brownout_sleep_off_cnt != 3'h0);
  assign brownout_sleep_off_active = brownout_sleep_off_bit &&
                       (state_reg.brownout_sleep_off_cnt <= spc_pkg::SPC_BROWNOUT_SLEEP_OFF_ACT_MAX);
  // All-ones fuse code means the monitor is disabled
  assign fuse_bod  = (brownout_level_fuses_i != 3'h7);

  always_comb begin
    state_next = state_reg;
    sleeping = 1'b0;
    deep = 1'b0;

    // APB: answer one cycle after setup, data registered
    state_next.pready  = setup_ph;
    state_next.pslverr = setup_ph &&
                         !(hit_core || hit_sleep || hit_gate || hit_stat);
    state_next.prdata  = 32'h0000_0000;
    if (setup_ph && !pwrite_i) begin
      if (hit_sleep) begin
        state_next.prdata[2:0] = state_reg.sleep_ctl;
      end else if (hit_gate) begin
        state_next.prdata[5:0] = state_reg.gate;
      end else if (hit_core) begin
        state_next.prdata[spc_pkg::SPC_BROWNOUT_SLEEP_OFF_BIT]   = brownout_sleep_off_bit;
        state_next.prdata[spc_pkg::SPC_UNLOCK_BIT] =
          (state_reg.unlock_cnt != 3'h0);
        state_next.prdata[spc_pkg::SPC_PUD_BIT]    = state_reg.pullup_disable;
      end else if (hit_stat) begin
        state_next.prdata[3:0] = state_reg.state;
        state_next.prdata[5:4] = state_reg.mode;
        state_next.prdata[6]   = brownout_sleep_off_active;
        state_next.prdata[7]   = state_reg.bod_off;
      end
    end

    // Sleep-off window and life counters
    if (state_reg.unlock_cnt != 3'h0) begin
      state_next.unlock_cnt = state_reg.unlock_cnt - 3'h1;
    end
    if (state_reg.brownout_sleep_off_cnt != 3'h0) begin
      state_next.brownout_sleep_off_cnt = state_reg.brownout_sleep_off_cnt - 3'h1;
    end

    if (wr_en && hit_sleep) begin
      state_next.sleep_ctl = pwdata_i[2:0];
    end
    if (wr_en && hit_gate) begin
      state_next.gate = pwdata_i[5:0];
    end
    if (wr_en && hit_core) begin
      state_next.pullup_disable = pwdata_i[spc_pkg::SPC_PUD_BIT];
      if (pwdata_i[spc_pkg::SPC_BROWNOUT_SLEEP_OFF_BIT] &&
          pwdata_i[spc_pkg::SPC_UNLOCK_BIT]) begin
        state_next.unlock_cnt = spc_pkg::SPC_UNLOCK_CYC;
      end else if (pwdata_i[spc_pkg::SPC_BROWNOUT_SLEEP_OFF_BIT] &&
                   state_reg.unlock_cnt != 3'h0) begin
        // Only the second step of the timed sequence sets the bit
        state_next.brownout_sleep_off_cnt   = spc_pkg::SPC_BROWNOUT_SLEEP_OFF_CYC;
        state_next.unlock_cnt = 3'h0;
      end
    end

    unique case (state_reg.state)
      spc_pkg::SPC_ST_RUN: begin
        if (sleep_instr_i &&
            state_reg.sleep_ctl[spc_pkg::SPC_SE_BIT]) begin
          state_next.state = spc_pkg::SPC_ST_SLEEP;
          state_next.mode  = state_reg.sleep_ctl[2:1];
          // Sleep-off only matters where the monitor may drop out
          state_next.bod_off = brownout_sleep_off_active &&
                               deep_mode(state_reg.sleep_ctl[2:1]);
        end
      end
      spc_pkg::SPC_ST_SLEEP: begin
        if (wake_i) begin
          state_next.bod_off = 1'b0;
          if (deep_mode(state_reg.mode)) begin
            state_next.state  = spc_pkg::SPC_ST_START;
            state_next.su_cnt = STARTUP_CYC;
          end else begin
            state_next.state    = spc_pkg::SPC_ST_HALT;
            state_next.halt_cnt = spc_pkg::SPC_WAKE_HALT;
          end
        end
      end
      spc_pkg::SPC_ST_START: begin
        if (state_reg.su_cnt <= 16'h0001) begin
          state_next.state    = spc_pkg::SPC_ST_HALT;
          state_next.halt_cnt = spc_pkg::SPC_WAKE_HALT;
        end else begin
          state_next.su_cnt = state_reg.su_cnt - 16'h0001;
        end
      end
      spc_pkg::SPC_ST_HALT: begin
        if (state_reg.halt_cnt <= 3'h1) begin
          state_next.state = spc_pkg::SPC_ST_RUN;
        end else begin
          state_next.halt_cnt = state_reg.halt_cnt - 3'h1;
        end
      end
      default: begin
        state_next.state = spc_pkg::SPC_ST_RUN;
      end
    endcase

    // Outputs follow the next control state so they leave flip-flops
    sleeping = (state_next.state == spc_pkg::SPC_ST_SLEEP);
    deep     = sleeping && deep_mode(state_next.mode);
    state_next.cpu_halt = (state_next.state != spc_pkg::SPC_ST_RUN);
    state_next.clk_cpu  = !state_next.cpu_halt;
    state_next.clk_io   = !sleeping ||
                          (state_next.mode == spc_pkg::SPC_MODE_IDLE);
    state_next.clk_adc  = !sleeping || !deep_mode(state_next.mode);
    state_next.clk_asy  = !sleeping ||
                          (state_next.mode != spc_pkg::SPC_MODE_PDWN);
    state_next.main_osc = state_next.clk_adc ||
                          onchip_debug_fuse_i;
    // The clock enable also gates the peripheral's register strobes,
    // so state holds and bus accesses are dropped while gated
    state_next.periph_clk = ~state_next.gate &
                            {{5{state_next.clk_io}},
                             state_next.clk_adc};
    state_next.adc_en   = adc_enable_i;
    state_next.adc_prev = adc_enable_i;
    if (adc_enable_i && !state_reg.adc_prev) begin
      state_next.ext_conv = 1'b1;
    end else if (adc_conv_start_i) begin
      state_next.ext_conv = 1'b0;
    end
    state_next.acomp_en = acomp_enable_i && !deep;
    state_next.bod_en   = fuse_bod && !state_next.bod_off;
    state_next.vref_en  = state_next.bod_en || adc_enable_i ||
                          (acomp_enable_i && acomp_uses_ref_i);
    state_next.wdt_run  = wdt_enable_i;
    state_next.inbuf    = deep ? wake_pin_need_i : 16'hFFFF;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg            <= '0;
      state_reg.state      <= spc_pkg::SPC_ST_RUN;
      state_reg.sleep_ctl  <= spc_pkg::SPC_SLEEP_RST;
      state_reg.gate       <= spc_pkg::SPC_GATE_RST;
      state_reg.clk_cpu    <= 1'b1;
      state_reg.clk_io     <= 1'b1;
      state_reg.clk_adc    <= 1'b1;
      state_reg.clk_asy    <= 1'b1;
      state_reg.main_osc   <= 1'b1;
      state_reg.periph_clk <= 6'h3F;
      state_reg.inbuf      <= 16'hFFFF;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata_o            = state_reg.prdata;
  assign pready_o            = state_reg.pready;
  assign pslverr_o           = state_reg.pslverr;
  assign cpu_halt_o          = state_reg.cpu_halt;
  assign clk_cpu_en_o        = state_reg.clk_cpu;
  assign clk_io_en_o         = state_reg.clk_io;
  assign clk_adc_en_o        = state_reg.clk_adc;
  assign clk_asy_en_o        = state_reg.clk_asy;
  assign main_osc_en_o       = state_reg.main_osc;
  assign periph_clk_en_o     = state_reg.periph_clk;
  assign adc_en_o            = state_reg.adc_en;
  assign adc_extended_conv_o = state_reg.ext_conv;
  assign acomp_en_o          = state_reg.acomp_en;
  assign vref_en_o           = state_reg.vref_en;
  assign wdt_run_o           = state_reg.wdt_run;
  assign brownout_en_o       = state_reg.bod_en;
  assign input_buf_en_o      = state_reg.inbuf;
  assign pullup_disable_o    = state_reg.pullup_disable;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  logic in_run;
  logic in_halt;
  logic deep_sleep;
  assign in_run     = (state_reg.state == spc_pkg::SPC_ST_RUN);
  assign in_halt    = (state_reg.state == spc_pkg::SPC_ST_HALT);
  assign deep_sleep = (state_reg.state == spc_pkg::SPC_ST_SLEEP) &&
                      deep_mode(state_reg.mode);

  sequence seq_brownout_sleep_off_wait;
    (brownout_sleep_off_bit && !brownout_sleep_off_active) [*3];
  endsequence
  sequence seq_brownout_sleep_off_live;
    brownout_sleep_off_active [*3];
  endsequence
  sequence seq_halt_four;
    (in_halt && cpu_halt_o) [*4];
  endsequence

  AST_NO_ARM: assert property (
    in_run && sleep_instr_i && !state_reg.sleep_ctl[0] |=>
      in_run && clk_cpu_en_o)
    else $error("unarmed sleep instruction stopped the core");

  AST_MODE_LATCH: assert property (
    in_run && sleep_instr_i && state_reg.sleep_ctl[0] |=>
      cpu_halt_o && state_reg.mode == $past(state_reg.sleep_ctl[2:1]))
    else $error("sleep entry did not take the chosen mode");

  AST_RSVD_ZERO: assert property (
    pready_o && $past(hit_sleep || hit_gate) |->
      prdata_o[31:6] == 26'h0)
    else $error("reserved bits read nonzero");

  AST_GATE_RUN: assert property (
    in_run |-> periph_clk_en_o == ~state_reg.gate)
    else $error("peripheral clock enable disagrees with gate bits");

  AST_BROWNOUT_SLEEP_OFF_UNLOCK: assert property (
    $rose(brownout_sleep_off_bit) |-> $past(state_reg.unlock_cnt != 3'h0))
    else $error("sleep-off bit set without unlock window");

  AST_BROWNOUT_SLEEP_OFF_TIME: assert property (
    $rose(brownout_sleep_off_bit) |-> seq_brownout_sleep_off_wait ##1 seq_brownout_sleep_off_live ##1 !brownout_sleep_off_bit)
    else $error("sleep-off bit timing wrong");

  AST_BOD_BACK: assert property (
    !deep_sleep && fuse_bod |=>
      brownout_en_o || (deep_sleep && state_reg.bod_off))
    else $error("brown-out monitor not on outside sleep");

  AST_WAKE_HALT: assert property (
    $rose(in_halt) |-> seq_halt_four ##1 in_run && !cpu_halt_o)
    else $error("wake halt not four cycles");

  AST_INBUF: assert property (
    deep_sleep |=> input_buf_en_o == $past(wake_pin_need_i) ||
                   !deep_sleep)
    else $error("input buffers enabled in deep sleep");

  AST_ACOMP_VREF: assert property (
    acomp_enable_i && acomp_uses_ref_i |=> vref_en_o)
    else $error("reference dropped while comparator uses it");

  AST_DEBUG_OSC: assert property (
    onchip_debug_fuse_i |=> main_osc_en_o)
    else $error("main clock stopped with debug fuse programmed");

endmodule

// ===== dv/spc_far_model.sv
// CPU core and one gated peripheral facing the power controller
`timescale 1ns/1ps
module spc_far_model (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // From the controller
  input  wire logic        cpu_halt_i,
  input  wire logic [5:0]  periph_clk_en_i,
  // To the controller and bench
  output logic             sleep_instr_o,
  output logic             wake_o,
  output logic      [15:0] lin_count_o
);
  initial begin
    sleep_instr_o = 1'b0;
    wake_o = 1'b0;
  end

  // Peripheral state advances only while its clock runs
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lin_count_o <= 16'h0000;
    end else if (periph_clk_en_i[5]) begin
      lin_count_o <= lin_count_o + 16'h0001;
    end
  end

  // A halted core cannot issue the instruction, so it is skipped then
  task automatic do_sleep(input int lead);
    repeat (lead) @(posedge mclk_i);
    if (cpu_halt_i === 1'b0) begin
      sleep_instr_o <= 1'b1;
      @(posedge mclk_i);
      sleep_instr_o <= 1'b0;
    end
  endtask

  // Edges from the wake sample until the core runs again
  task automatic do_wake(output int n);
    n = 0;
    @(posedge mclk_i);
    wake_o <= 1'b1;
    do begin
      @(posedge mclk_i);
      wake_o <= 1'b0;
      n++;
      #1;
    end while (cpu_halt_i !== 1'b0 && n < 200);
  endtask
endmodule

// ===== dv/tb.sv
// Self-checking bench for the sleep and power control block
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] STARTUP = 16'h0002;
  localparam logic [11:0] A_CORE  = {2'b00, spc_pkg::SPC_IDX_CORE, 2'b00};
  localparam logic [11:0] A_SLEEP = {2'b00, spc_pkg::SPC_IDX_SLEEP, 2'b00};
  localparam logic [11:0] A_GATE  = {2'b00, spc_pkg::SPC_IDX_GATE, 2'b00};
  // Clock enables expected per mode, bit m for mode m
  localparam logic [3:0]  IO_EXP  = 4'h1;
  localparam logic [3:0]  ADC_EXP = 4'h3;
  localparam logic [3:0]  ASY_EXP = 4'hB;

  logic        mclk = 1'b0;
  logic        rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        sleep_instr, wake, cpu_halt, clk_cpu_en, clk_io_en;
  logic        clk_adc_en, clk_asy_en, main_osc_en, dbg_fuse, adc_en_req;
  logic        adc_conv, acomp_req, acomp_ref, wdt_req, adc_en, adc_ext;
  logic        acomp_en, vref_en, wdt_run, bod_en, pullup_disable;
  logic [5:0]  periph_clk_en;
  logic [2:0]  fuses;
  logic [15:0] wake_need, ibuf_en, lin_count;
  int          n_fail = 0;
  int          checked = 0;
  int          cycles = 0;

  always #5 mclk = ~mclk;

  spc_sleep_power_ctrl #(.STARTUP_CYC(STARTUP)) i_dut (
    .mclk_i(mclk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .sleep_instr_i(sleep_instr), .wake_i(wake), .cpu_halt_o(cpu_halt),
    .clk_cpu_en_o(clk_cpu_en), .clk_io_en_o(clk_io_en),
    .clk_adc_en_o(clk_adc_en), .clk_asy_en_o(clk_asy_en),
    .main_osc_en_o(main_osc_en), .periph_clk_en_o(periph_clk_en),
    .brownout_level_fuses_i(fuses), .onchip_debug_fuse_i(dbg_fuse),
    .adc_enable_i(adc_en_req), .adc_conv_start_i(adc_conv),
    .acomp_enable_i(acomp_req), .acomp_uses_ref_i(acomp_ref),
    .wdt_enable_i(wdt_req), .wake_pin_need_i(wake_need),
    .adc_en_o(adc_en), .adc_extended_conv_o(adc_ext),
    .acomp_en_o(acomp_en), .vref_en_o(vref_en), .wdt_run_o(wdt_run),
    .brownout_en_o(bod_en), .input_buf_en_o(ibuf_en),
    .pullup_disable_o(pullup_disable));

  spc_far_model i_far (
    .mclk_i(mclk), .rst_i(rst), .cpu_halt_i(cpu_halt),
    .periph_clk_en_i(periph_clk_en), .sleep_instr_o(sleep_instr),
    .wake_o(wake), .lin_count_o(lin_count));

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got 0x%08h expected 0x%08h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    int t;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, wd};
    @(posedge mclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 50) begin
      n_fail++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                        input logic experr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, exp);
    chk(32'(e), 32'(experr));
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // A hang ends the run as a mismatch
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    logic [31:0] c0;
    logic [5:0]  exp6;
    logic        deep;
    int          n;
    rst = 1'b1;
    {psel, penable, pwrite, adc_conv, acomp_ref, dbg_fuse} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    {adc_en_req, acomp_req, wdt_req} = 3'h7;
    fuses = 3'h4;
    wake_need = 16'h00F0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    tick(1);
    chk(32'({cpu_halt, periph_clk_en}), 32'h3F);
    rd_chk(A_SLEEP, 32'h0, 1'b0);
    rd_chk(A_GATE, 32'h0, 1'b0);
    rd_chk(A_CORE, 32'h0, 1'b0);
    wr(A_SLEEP, 8'hFF);
    rd_chk(A_SLEEP, 32'h07, 1'b0);
    wr(A_GATE, 8'hFF);
    rd_chk(A_GATE, 32'h3F, 1'b0);
    wr(A_CORE, 8'h9F);
    rd_chk(A_CORE, 32'h10, 1'b0);
    chk(32'(pullup_disable), 32'h1);
    rd_chk(12'h0FC, 32'h0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      wr(A_GATE, 8'(1 << i));
      tick(2);
      exp6 = ~(6'h01 << i);
      chk(32'(periph_clk_en), 32'(exp6));
    end
    c0 = 32'(lin_count);
    tick(5);
    chk(32'(lin_count), c0);
    wr(A_GATE, 8'h00);
    tick(3);
    chk(32'(32'(lin_count) != c0), 32'h1);
    // Lone sleep-off write without unlock must not disable the monitor
    wr(A_CORE, 8'h40);
    wr(A_GATE, 8'h02);
    for (int m = 0; m < 4; m++) begin
      wr(A_SLEEP, {5'h00, 2'(m), 1'b1});
      i_far.do_sleep(1);
      tick(2);
      deep = (m >= 2);
      chk(32'({cpu_halt, clk_cpu_en, clk_io_en, clk_adc_en, clk_asy_en}),
          32'({2'b10, IO_EXP[m], ADC_EXP[m], ASY_EXP[m]}));
      chk(32'({acomp_en, adc_en, wdt_run, bod_en, vref_en, main_osc_en}),
          32'({~deep, 4'hF, ~deep}));
      chk(32'(ibuf_en), deep ? 32'h00F0 : 32'hFFFF);
      if (m == 0) begin
        chk(32'(periph_clk_en), 32'h3D);
      end
      i_far.do_wake(n);
      chk(32'(n), deep ? 32'(16'h0005 + STARTUP) : 32'h5);
      wr(A_SLEEP, 8'h00);
    end
    wr(A_SLEEP, {5'h00, spc_pkg::SPC_MODE_PDWN, 1'b0});
    i_far.do_sleep(1);
    tick(2);
    chk(32'({cpu_halt, clk_cpu_en, clk_io_en}), 32'h3);
    // Clear the flag left by the enable at reset release first
    @(posedge mclk);
    adc_conv <= 1'b1;
    @(posedge mclk);
    adc_conv <= 1'b0;
    tick(1);
    chk(32'(adc_ext), 32'h0);
    @(posedge mclk);
    adc_en_req <= 1'b0;
    @(posedge mclk);
    adc_en_req <= 1'b1;
    tick(3);
    chk(32'(adc_ext), 32'h1);
    @(posedge mclk);
    adc_conv <= 1'b1;
    @(posedge mclk);
    adc_conv <= 1'b0;
    tick(1);
    chk(32'(adc_ext), 32'h0);
    @(posedge mclk);
    fuses <= 3'h7;
    adc_en_req <= 1'b0;
    tick(3);
    chk(32'({vref_en, bod_en}), 32'h0);
    @(posedge mclk);
    acomp_ref <= 1'b1;
    tick(3);
    chk(32'(vref_en), 32'h1);
    @(posedge mclk);
    fuses <= 3'h4;
    dbg_fuse <= 1'b1;
    wr(A_SLEEP, {5'h00, spc_pkg::SPC_MODE_PDWN, 1'b1});
    wr(A_CORE, 8'h60);
    wr(A_CORE, 8'h40);
    i_far.do_sleep(3);
    tick(2);
    chk(32'({bod_en, main_osc_en, cpu_halt}), 32'h3);
    i_far.do_wake(n);
    tick(1);
    chk(32'(bod_en), 32'h1);
    rd_chk(A_CORE, 32'h0, 1'b0);
    end_of_test();
  end
endmodule
